// >>> core/tpc_regs.svh
// Purpose: Constants of the transmitter protection controller.
// Assumes: 10 MHz system clock; all percentages are of full scale.
// Notes:   Timing figures are in their own units; cycles are derived.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// ********************************************************************
// Timing
// ********************************************************************
`define TPC_CLK_NS    100
`define TPC_TICK_NS   1000000000
`define TPC_DEB_NS    10000000
`define TPC_COOL_S    180
`define TPC_PERIOD_S  7200
`define TPC_RUN_S     120
`define TPC_RESTART_S 10
`define TPC_QUIET_S   1800

// ********************************************************************
// Protection and thresholds
// ********************************************************************
`define TPC_ALM_MAX   8
`define TPC_FWD_FS_W  5000
`define TPC_RFL_FS_W  500
`define TPC_FULL_PCT  8'h64
`define TPC_TRIP_PCT  8'h78
`define TPC_FB_BASE   8'h0a
`define TPC_THR_RST   32'h5f463250
`define TPC_SET_SRC   8'h50
`define TPC_ADDR_RST  7'h01

`endif

// >>> core/tpc_pkg.sv
// Purpose: Types of the transmitter protection controller.
// Assumes: Measurement index 0 forward, 1 reflected, 2 rejected, 3 temp.
// Notes:   Constants live in tpc_regs.svh.
package tpc_pkg;
  typedef enum logic [1:0] {TPC_OFF, TPC_ON, TPC_WAIT, TPC_FAULT} tpc_mode_e;
  typedef enum logic [1:0] {TPC_CYCLIC, TPC_HOLD, TPC_DIS} tpc_prot_e;
  typedef tpc_prot_e [3:0] tpc_modes_t;
  typedef logic [3:0][7:0] tpc_pct4_t;
  typedef struct packed {logic on; logic off; logic rst;} tpc_tel_s;
  typedef struct packed {
    logic on; logic off; logic rst; logic up; logic down; logic enter;
  } tpc_panel_s;
  typedef struct packed {tpc_tel_s tel; tpc_panel_s pnl;} tpc_keys_s;
  typedef struct packed {
    logic run; logic hold; logic fault; logic fold; logic loc;
  } tpc_leds_s;
  typedef struct packed {
    tpc_mode_e       mode;
    logic [8:0]      s1;
    logic [8:0]      s2;
    logic [8:0]      smp;
    logic [8:0]      lvl;
    tpc_keys_s       ev;
    logic [19:0]     deb_cnt;
    logic [23:0]     tick_cnt;
    logic [15:0]     cool;
    logic [15:0]     per;
    logic [15:0]     rst_cnt;
    logic [15:0]     quiet;
    logic [1:0]      cause;
    logic [3:0][3:0] cnt;
    tpc_pct4_t       thr;
    logic [1:0]      sel;
    logic            editing;
    logic [7:0]      ed_val;
    logic [6:0]      addr;
    logic            analog;
    logic [3:0]      setc;
    logic [7:0]      fb;
    logic            interlock;
    logic            aux;
    logic            blower;
    tpc_leds_s       leds;
  } tpc_state_s;
endpackage

// >>> core/tpc_core.sv
// Purpose: Supervisory protection controller for an RF hybrid coupler.
// Assumes: Inputs synchronous to mclk; telemetry commands active low.
// Notes:   All long intervals run on a one-second tick.
`timescale 1ns/100ps
`include "tpc_regs.svh"

module tpc_core #(
  parameter int unsigned TICK_CYC  = `TPC_TICK_NS / `TPC_CLK_NS,
  parameter int unsigned DEB_CYC   = `TPC_DEB_NS / `TPC_CLK_NS,
  parameter int unsigned COOL_S    = `TPC_COOL_S,
  parameter int unsigned PERIOD_S  = `TPC_PERIOD_S,
  parameter int unsigned RUN_S     = `TPC_RUN_S,
  parameter int unsigned RESTART_S = `TPC_RESTART_S,
  parameter int unsigned QUIET_S   = `TPC_QUIET_S,
  parameter int unsigned ALM_MAX   = `TPC_ALM_MAX
) (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire tpc_pkg::tpc_panel_s panel,
  input  wire tpc_pkg::tpc_tel_s   tel_n,
  input  wire logic                local_mode,
  input  wire logic                alm_view,
  input  wire tpc_pkg::tpc_pct4_t  meas,
  input  wire tpc_pkg::tpc_modes_t prot_mode,
  input  wire logic [6:0]          cfg_addr,
  input  wire logic                cfg_addr_wr,
  input  wire logic                cfg_analog,
  input  wire logic                cfg_style_wr,
  output logic                     interlock,
  output logic                     aux_relay,
  output logic                     blower,
  output tpc_pkg::tpc_leds_s       leds,
  output logic [7:0]               fb_level,
  output logic [3:0]               set_closed,
  output logic [1:0]               cause,
  output logic [3:0][3:0]          alm_cnt,
  output tpc_pkg::tpc_pct4_t       thr,
  output logic [1:0]               edit_sel,
  output logic                     edit_active,
  output logic [7:0]               edit_val,
  output logic [6:0]               bus_addr,
  output logic                     disp_analog
);

  // ******************************************************************
  // Parameter checks
  // ******************************************************************
  // Counter widths are fixed in the state record, so oversize values
  // would silently wrap.
  if (TICK_CYC < 2 || TICK_CYC > 24'hffffff || DEB_CYC < 2 ||
      DEB_CYC > 20'hfffff || ALM_MAX < 1 || ALM_MAX > 4'hf ||
      COOL_S > 16'hffff || PERIOD_S < 1 || PERIOD_S > 16'hffff ||
      RUN_S > 16'hffff || RESTART_S < 1 || RESTART_S > 16'hffff ||
      QUIET_S < 1 || QUIET_S > 16'hffff) begin : g_bad_param
    $error("tpc_core: parameter out of supported range");
  end

  // ******************************************************************
  // State
  // ******************************************************************
  tpc_pkg::tpc_state_s s_reg;
  tpc_pkg::tpc_state_s s_next;
  logic [8:0]          raw;

  // Telemetry lines are active low, so they are inverted at entry.
  assign raw = {~tel_n, panel};

  // Next-state logic for the whole controller.
  always_comb begin
    logic       tick;
    logic       loc;
    logic       c_on;
    logic       c_off;
    logic       c_rst;
    logic [8:0] diff;
    logic [3:0] over;
    logic [3:0] trip;
    logic [1:0] idx;
    logic [3:0] cn;
    logic [7:0] xs;
    logic [7:0] src;
    tick  = 1'b0;
    loc   = local_mode;
    c_on  = 1'b0;
    c_off = 1'b0;
    c_rst = 1'b0;
    diff  = '0;
    over  = '0;
    trip  = '0;
    idx   = '0;
    cn    = '0;
    xs    = '0;
    src   = `TPC_SET_SRC;
    s_next = s_reg;

    // Common one-second tick for every long interval.
    tick = (s_reg.tick_cnt == 24'(TICK_CYC - 1));
    s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 24'h1;

    // Two-flop synchroniser, then a level kept only when two slow
    // samples agree; a press becomes one registered edge pulse.
    s_next.s1 = raw;
    s_next.s2 = s_reg.s1;
    if (s_reg.deb_cnt == 20'(DEB_CYC - 1)) begin
      s_next.deb_cnt = '0;
      s_next.smp = s_reg.s2;
      diff = s_reg.s2 ^ s_reg.smp;
      s_next.lvl = (s_reg.s2 & ~diff) | (s_reg.lvl & diff);
    end else begin
      s_next.deb_cnt = s_reg.deb_cnt + 20'h1;
    end
    s_next.ev = tpc_pkg::tpc_keys_s'(s_next.lvl & ~s_reg.lvl);

    // Panel commands only in local, telemetry only in remote.
    c_on  = loc ? s_reg.ev.pnl.on  : s_reg.ev.tel.on;
    c_off = loc ? s_reg.ev.pnl.off : s_reg.ev.tel.off;
    c_rst = loc ? s_reg.ev.pnl.rst : s_reg.ev.tel.rst;

    // Foldback on the four linked variables; the largest excess wins.
    for (int i = 0; i < 4; i++) begin
      if (meas[i] > `TPC_FULL_PCT) begin
        if (8'(meas[i] - `TPC_FULL_PCT) > xs) begin
          xs = 8'(meas[i] - `TPC_FULL_PCT);
        end
      end
      over[i] = (meas[i] > `TPC_TRIP_PCT);
      trip[i] = over[i] && (prot_mode[i] != tpc_pkg::TPC_DIS);
    end
    s_next.fb = 8'(`TPC_FB_BASE + xs);
    s_next.leds.fold = (xs != 8'h00);
    for (int i = 3; i >= 0; i--) begin
      if (trip[i]) begin
        idx = 2'(i);
      end
    end

    // Comparators on percent-of-full-scale thresholds.
    for (int i = 0; i < 4; i++) begin
      s_next.setc[i] = meas[src[2*i +: 2]] > s_reg.thr[i];
    end

    // Protection sequence.
    case (s_reg.mode)
      tpc_pkg::TPC_OFF: begin
        if (c_on) begin
          s_next.mode = tpc_pkg::TPC_ON;
        end
      end
      tpc_pkg::TPC_ON: begin
        if (c_off) begin
          s_next.mode = tpc_pkg::TPC_OFF;
        end else if (|trip) begin
          s_next.cause = idx;
          s_next.quiet = '0;
          if (prot_mode[idx] == tpc_pkg::TPC_CYCLIC) begin
            cn = s_reg.cnt[idx] + 4'h1;
            s_next.cnt[idx] = cn;
            s_next.rst_cnt = 16'(RESTART_S);
            s_next.mode = (cn >= 4'(ALM_MAX)) ? tpc_pkg::TPC_FAULT
                                              : tpc_pkg::TPC_WAIT;
          end else begin
            s_next.mode = tpc_pkg::TPC_WAIT;
          end
        end else begin
          // Reset while transmitting only acts from the alarm screen,
          // so no reset in the on state wipes alarms unseen.
          if (c_rst && alm_view) begin
            s_next.cnt = '0;
          end
          if (tick) begin
            if (s_reg.quiet == 16'(QUIET_S - 1)) begin
              s_next.quiet = '0;
              s_next.cnt = '0;
            end else begin
              s_next.quiet = s_reg.quiet + 16'h1;
            end
          end
        end
      end
      tpc_pkg::TPC_WAIT: begin
        if (c_off) begin
          s_next.mode = tpc_pkg::TPC_OFF;
        end else if (c_rst) begin
          s_next.mode = tpc_pkg::TPC_ON;
          s_next.cnt = '0;
        end else if (prot_mode[s_reg.cause] == tpc_pkg::TPC_CYCLIC) begin
          if (tick) begin
            s_next.rst_cnt = s_reg.rst_cnt - 16'h1;
            if (s_reg.rst_cnt <= 16'h1) begin
              s_next.mode = tpc_pkg::TPC_ON;
            end
          end
        end else if (!over[s_reg.cause]) begin
          s_next.mode = tpc_pkg::TPC_ON;
        end
      end
      tpc_pkg::TPC_FAULT: begin
        if (c_off) begin
          s_next.mode = tpc_pkg::TPC_OFF;
        end else if (c_rst) begin
          s_next.mode = tpc_pkg::TPC_ON;
          s_next.cnt = '0;
        end
      end
      default: begin
        s_next.mode = tpc_pkg::TPC_OFF;
      end
    endcase

    // Blowers: cooling run after leaving on, then a short exercise run
    // every period while the coupler stays off.
    if (s_reg.mode == tpc_pkg::TPC_ON) begin
      if (s_next.mode != tpc_pkg::TPC_ON) begin
        s_next.cool = 16'(COOL_S);
        s_next.per = '0;
      end
    end else if (tick) begin
      if (s_reg.cool != 16'h0) begin
        s_next.cool = s_reg.cool - 16'h1;
      end else if (s_reg.per == 16'(PERIOD_S - 1)) begin
        s_next.per = '0;
        s_next.cool = 16'(RUN_S);
      end else begin
        s_next.per = s_reg.per + 16'h1;
      end
    end

    // Threshold editing and settings, refused in remote mode.
    if (loc) begin
      if (!s_reg.editing) begin
        if (s_reg.ev.pnl.up) begin
          s_next.sel = s_reg.sel - 2'h1;
        end else if (s_reg.ev.pnl.down) begin
          s_next.sel = s_reg.sel + 2'h1;
        end else if (s_reg.ev.pnl.enter) begin
          s_next.editing = 1'b1;
          s_next.ed_val = s_reg.thr[s_reg.sel];
        end
      end else begin
        if (s_reg.ev.pnl.up && s_reg.ed_val < `TPC_FULL_PCT) begin
          s_next.ed_val = s_reg.ed_val + 8'h1;
        end else if (s_reg.ev.pnl.down && s_reg.ed_val != 8'h0) begin
          s_next.ed_val = s_reg.ed_val - 8'h1;
        end else if (s_reg.ev.pnl.enter) begin
          s_next.thr[s_reg.sel] = s_reg.ed_val;
          s_next.editing = 1'b0;
        end
      end
      if (cfg_addr_wr) begin
        s_next.addr = cfg_addr;
      end
      if (cfg_style_wr) begin
        s_next.analog = cfg_analog;
      end
    end

    // Outputs, all registered.
    s_next.interlock = (s_next.mode != tpc_pkg::TPC_ON);
    s_next.aux = (s_next.mode == tpc_pkg::TPC_ON);
    s_next.blower = s_next.aux || (s_next.cool != 16'h0);
    s_next.leds.run = s_next.aux;
    s_next.leds.hold = (s_next.mode == tpc_pkg::TPC_WAIT);
    s_next.leds.fault = (s_next.mode == tpc_pkg::TPC_FAULT);
    s_next.leds.loc = loc;
  end

  // State register; reset leaves the coupler off with blowers idle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.mode <= tpc_pkg::TPC_OFF;
      s_reg.thr <= `TPC_THR_RST;
      s_reg.addr <= `TPC_ADDR_RST;
      s_reg.fb <= `TPC_FB_BASE;
      s_reg.interlock <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign interlock   = s_reg.interlock;
  assign aux_relay   = s_reg.aux;
  assign blower      = s_reg.blower;
  assign leds        = s_reg.leds;
  assign fb_level    = s_reg.fb;
  assign set_closed  = s_reg.setc;
  assign cause       = s_reg.cause;
  assign alm_cnt     = s_reg.cnt;
  assign thr         = s_reg.thr;
  assign edit_sel    = s_reg.sel;
  assign edit_active = s_reg.editing;
  assign edit_val    = s_reg.ed_val;
  assign bus_addr    = s_reg.addr;
  assign disp_analog = s_reg.analog;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_OFF_INTERLOCK: assert property (
    s_reg.mode == tpc_pkg::TPC_OFF |-> interlock && !aux_relay)
    else $error("off without interlock");
  AST_COOL_RUN: assert property (
    $fell(aux_relay) |-> blower ##1 blower)
    else $error("blowers stopped at switch off");
  AST_ON_RELEASE: assert property (
    s_reg.mode == tpc_pkg::TPC_ON |-> !interlock && aux_relay && blower)
    else $error("on state without release");
  AST_SET_CMP: assert property (
    ##1 set_closed[0] == ($past(meas[0]) > $past(s_reg.thr[0])))
    else $error("threshold compare wrong");
  AST_FOLD_IDLE: assert property (
    (meas[0] <= `TPC_FULL_PCT && meas[1] <= `TPC_FULL_PCT &&
     meas[2] <= `TPC_FULL_PCT && meas[3] <= `TPC_FULL_PCT)
    |=> !leds.fold && fb_level == `TPC_FB_BASE)
    else $error("foldback active within full scale");
  AST_TRIP_STBY: assert property (
    s_reg.mode == tpc_pkg::TPC_ON && meas[0] > `TPC_TRIP_PCT &&
    prot_mode[0] != tpc_pkg::TPC_DIS && !s_reg.ev.pnl.off &&
    !s_reg.ev.tel.off |=> interlock)
    else $error("trip did not force standby");
  AST_WAIT_LED: assert property (
    s_reg.mode == tpc_pkg::TPC_WAIT |-> leds.hold && !leds.run)
    else $error("wait indicator wrong");
  AST_FAULT_HOLD: assert property (
    s_reg.mode == tpc_pkg::TPC_FAULT && !s_reg.ev.pnl.rst &&
    !s_reg.ev.tel.rst && !s_reg.ev.pnl.off && !s_reg.ev.tel.off
    |=> leds.fault && interlock)
    else $error("fault left without reset");
  AST_RESET_ON: assert property (
    (s_reg.mode == tpc_pkg::TPC_WAIT || s_reg.mode == tpc_pkg::TPC_FAULT)
    && local_mode && s_reg.ev.pnl.rst && !s_reg.ev.pnl.off
    |=> s_reg.mode == tpc_pkg::TPC_ON && alm_cnt == '0)
    else $error("alarm reset did not restart");
endmodule

// >>> testbench/tpc_exciter.sv
// Purpose: Behavioural exciter that stands on the far side of the core.
// Assumes: Forward power follows drive one cycle late while emitting.
// Notes:   Emission needs interlock released and the aux relay closed.
`timescale 1ns/100ps

module tpc_exciter (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       interlock,
  input  wire logic       aux_relay,
  input  wire logic [7:0] drive,
  output logic      [7:0] fwd
);
  // ******************************************************************
  // RF output
  // ******************************************************************
  // Registered so the core never sees power change in the same cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fwd <= 8'h00;
    end else if (interlock || !aux_relay) begin
      fwd <= 8'h00; // Standby or unpowered gives no RF at all.
    end else begin
      fwd <= drive;
    end
  end
endmodule

// >>> testbench/tb_transmitter_protection_controller.sv
// Purpose: Self-checking bench for the protection controller core.
// Assumes: Short tick and debounce counts so the run stays brief.
// Notes:   Forward power comes from the exciter model, the rest direct.
`timescale 1ns/100ps

module tb_transmitter_protection_controller;
  // ******************************************************************
  // Signals
  // ******************************************************************
  localparam logic [5:0] K_ON  = 6'h20;
  localparam logic [5:0] K_OFF = 6'h10;
  localparam logic [5:0] K_RST = 6'h08;
  localparam logic [5:0] K_UP  = 6'h04;
  localparam logic [5:0] K_DN  = 6'h02;
  localparam logic [5:0] K_EN  = 6'h01;
  logic                mclk;
  logic                nrst;
  tpc_pkg::tpc_panel_s panel;
  tpc_pkg::tpc_tel_s   tel_n;
  logic                local_mode;
  logic                alm_view;
  logic [7:0]          drive;
  logic [7:0]          fwd;
  logic [7:0]          m1;
  logic [7:0]          m2;
  logic [7:0]          m3;
  tpc_pkg::tpc_pct4_t  meas;
  tpc_pkg::tpc_modes_t prot_mode;
  logic [6:0]          cfg_addr;
  logic                cfg_addr_wr;
  logic                cfg_analog;
  logic                cfg_style_wr;
  logic                interlock;
  logic                aux_relay;
  logic                blower;
  tpc_pkg::tpc_leds_s  leds;
  logic [7:0]          fb_level;
  logic [3:0]          set_closed;
  logic [1:0]          cause;
  logic [3:0][3:0]     alm_cnt;
  tpc_pkg::tpc_pct4_t  thr;
  logic [1:0]          edit_sel;
  logic                edit_active;
  logic [7:0]          edit_val;
  logic [6:0]          bus_addr;
  logic                disp_analog;
  int                  n_errors;
  int                  checked;
  int                  cyc;
  int                  c;

  assign meas = {m3, m2, m1, fwd};

  // ******************************************************************
  // Instances
  // ******************************************************************
  // Cooling, exercise run and restart keep their full tick counts, so
  // the off sequence is long enough to be seen after the key press.
  tpc_core #(.TICK_CYC(4), .DEB_CYC(2), .PERIOD_S(8), .QUIET_S(20),
    .ALM_MAX(2)) uut (
    .mclk(mclk), .nrst(nrst), .panel(panel), .tel_n(tel_n),
    .local_mode(local_mode), .alm_view(alm_view), .meas(meas),
    .prot_mode(prot_mode), .cfg_addr(cfg_addr),
    .cfg_addr_wr(cfg_addr_wr), .cfg_analog(cfg_analog),
    .cfg_style_wr(cfg_style_wr), .interlock(interlock),
    .aux_relay(aux_relay), .blower(blower), .leds(leds),
    .fb_level(fb_level), .set_closed(set_closed), .cause(cause),
    .alm_cnt(alm_cnt), .thr(thr), .edit_sel(edit_sel),
    .edit_active(edit_active), .edit_val(edit_val),
    .bus_addr(bus_addr), .disp_analog(disp_analog));
  tpc_exciter ex (.mclk(mclk), .nrst(nrst), .interlock(interlock),
    .aux_relay(aux_relay), .drive(drive), .fwd(fwd));

  // ******************************************************************
  // Tasks
  // ******************************************************************
  // Wide enough for the largest packed group compared in one call.
  task check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // A key held for several debounce samples counts as one press.
  task press(input logic [5:0] k);
    @(posedge mclk);
    panel <= k;
    cycles(12);
    @(posedge mclk);
    panel <= '0;
    cycles(12);
  endtask

  task tel(input logic [2:0] k);
    @(posedge mclk);
    tel_n <= ~k;
    cycles(20);
    @(posedge mclk);
    tel_n <= '1;
    cycles(12);
  endtask

  task cfg_wr;
    @(posedge mclk);
    cfg_addr <= 7'h2a;
    cfg_analog <= 1'b1;
    cfg_addr_wr <= 1'b1;
    cfg_style_wr <= 1'b1;
    @(posedge mclk);
    cfg_addr_wr <= 1'b0;
    cfg_style_wr <= 1'b0;
    cycles(2);
  endtask

  // Bounded wait on interlock or blower; the count is left in c.
  task wait_sig(input bit blw, input logic v);
    c = 0;
    while (((blw ? blower : interlock) !== v) && c < 1000) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask

  // Overdrive forward power until the core trips, then back off.
  task trip;
    @(posedge mclk);
    drive <= 8'h79;
    wait_sig(0, 1'b1);
    @(posedge mclk);
    drive <= 8'h32;
    #1;
  endtask

  // ******************************************************************
  // Clock and timeout
  // ******************************************************************
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // A hang is cut short well after the expected run length.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      end_sim();
    end
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    n_errors = 0; checked = 0; cyc = 0; c = 0;
    nrst = 1'b0; panel = '0; tel_n = '1; local_mode = 1'b0;
    alm_view = 1'b0; drive = 8'h3c; m1 = 8'h4b; m2 = 8'h00; m3 = 8'h00;
    prot_mode = '{default: tpc_pkg::TPC_CYCLIC};
    cfg_addr = 7'h00; cfg_addr_wr = 1'b0;
    cfg_analog = 1'b0; cfg_style_wr = 1'b0;
    cycles(3);
    check(interlock, 1'b1);
    check(aux_relay, 1'b0);
    check({blower, leds, fb_level}, 14'h000a);
    check(thr, 32'h5f463250);
    check({bus_addr, disp_analog}, 8'h02);
    check(alm_cnt, 16'h0000);
    @(posedge mclk);
    nrst <= 1'b1;
    // Remote: panel commands and writes are refused, telemetry works.
    press(K_ON);
    check(interlock, 1'b1);
    cfg_wr();
    check(bus_addr, 7'h01);
    tel(3'h4);
    check({interlock, aux_relay}, 2'b01);
    tel(3'h2);
    check({interlock, aux_relay}, 2'b10);
    @(posedge mclk);
    local_mode <= 1'b1;
    cycles(2);
    check(leds.loc, 1'b1);
    press(K_ON);
    check({interlock, aux_relay, blower, leds.run}, 4'h7);
    cycles(3);
    check(set_closed, 4'b0110);
    // Disabled rejected power only folds back; temperature folds too.
    @(posedge mclk);
    prot_mode[2] <= tpc_pkg::TPC_DIS;
    m2 <= 8'h79;
    cycles(20);
    check(interlock, 1'b0);
    check({leds.fold, fb_level}, 9'h11f);
    @(posedge mclk);
    m2 <= 8'h00;
    m3 <= 8'h69;
    cycles(3);
    check(fb_level, 8'h0f);
    @(posedge mclk);
    m3 <= 8'h00;
    cycles(3);
    check({leds.fold, fb_level}, 9'h00a);
    cfg_wr();
    check({bus_addr, disp_analog}, 8'h55);
    // Edit the second threshold up by one step.
    press(K_DN);
    check(edit_sel, 2'd1);
    press(K_EN);
    check({edit_active, edit_val}, 9'h132);
    press(K_UP);
    check(edit_val, 8'h33);
    press(K_EN);
    check({edit_active, thr}, 33'h05f463350);
    // Cyclic trip, timed restart, then quiet-time clearing.
    trip();
    check({leds.hold, cause, alm_cnt[0]}, 7'h41);
    wait_sig(0, 1'b0);
    check(c >= 36 && c < 40, 1'b1);
    press(K_RST);
    check(alm_cnt[0], 4'h1);
    cycles(100);
    check(alm_cnt, 16'h0000);
    trip();
    press(K_RST);
    check({interlock, alm_cnt}, 17'h00000);
    trip();
    wait_sig(0, 1'b0);
    @(posedge mclk);
    alm_view <= 1'b1;
    press(K_RST);
    check(alm_cnt, 16'h0000);
    @(posedge mclk);
    alm_view <= 1'b0;
    // Hold-mode temperature trip restarts only once cleared.
    prot_mode[3] <= tpc_pkg::TPC_HOLD;
    m3 <= 8'h79;
    wait_sig(0, 1'b1);
    cycles(60);
    check({interlock, leds.hold, cause}, 4'hf);
    check(alm_cnt[3], 4'h0);
    @(posedge mclk);
    m3 <= 8'h00;
    wait_sig(0, 1'b0);
    check(c < 5, 1'b1);
    // Two cyclic trips reach the limit and lock out.
    trip();
    wait_sig(0, 1'b0);
    trip();
    cycles(60);
    check({interlock, leds.fault}, 2'b11);
    press(K_ON);
    check(interlock, 1'b1);
    press(K_RST);
    check({interlock, leds.run, alm_cnt}, 18'h10000);
    // Off: cooling run, then periodic blower runs.
    press(K_OFF);
    check({interlock, aux_relay, blower}, 3'b101);
    // Cooling is 180 ticks of 4 cycles, counted from the off edge,
    // which lies some 19 cycles before the press task returns.
    wait_sig(1, 1'b0);
    check(c > 690 && c < 710, 1'b1);
    // Eight idle ticks, then a run of 120 ticks.
    wait_sig(1, 1'b1);
    check(c, 32);
    wait_sig(1, 1'b0);
    check(c, 480);
    end_sim();
  end
endmodule
